/* verilog/lower_order_connection_matrix.sv */
// Four-by-four VC-11 byte matrix with one 1+1 SNC protection group.
// Assumes pins asynchronous to clk_sys_i and a plain register port.
//
// Contract
// - Octet frames repeating every 500 us
// - 100 payload bytes plus V5 label
// - Unequipped N2 byte is all zero
// - One owner per timeslot, others refused; here a new map write replaces the owner and group legs override map entries
// - Make and remove connections on command
// - Connections carry kind, direction, point ids
// - Broadcast is many legs, one source
// - Hitless reconfiguration while no switch pending
// - Built-in unequipped VC-11 generator
// - Unconnected outputs get unequipped, SSF false
// - Bridge copies normal input to both
// - Selector picks working/protection within 50 ms
// - 1+1 unidirectional, no APS, SF/SD high
// - Hold-off 0 to 10 s, 100 ms steps
// - Revertive option, WTR 5 to 12 minutes
// - SF/SD source set by protection kind
// - Accepted commands depend on revert setting
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "locm_cfg.svh"
module lower_order_connection_matrix #(
    parameter int TICK_CYCLES = (`CLK_HZ / 1000) * `TICK_MS
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic timing_clock_in_i,
    input wire logic timing_frame_start_in_i,
    input wire logic [31:0] in_data_i,
    input wire logic [3:0] server_signal_fail_in_i,
    input wire logic [3:0] trail_signal_fail_in_i,
    input wire logic [3:0] trail_signal_degrade_in_i,
    output logic in_ready_o,
    input wire logic out_ready_i,
    output logic [31:0] out_data_o,
    output logic [3:0] out_fs_o,
    output logic [3:0] out_ssf_o,
    output logic out_strobe_o
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    localparam int PW = 46;
    logic [PW-1:0] pin_a;
    logic [PW-1:0] pin_b;
    logic ck_prev;
    wire [PW-1:0] pin_now = {timing_clock_in_i, timing_frame_start_in_i, in_data_i,
        server_signal_fail_in_i, trail_signal_fail_in_i, trail_signal_degrade_in_i};
    wire ck_s = pin_b[45];
    wire fs_s = pin_b[44];
    wire [31:0] data_s = pin_b[43:12];
    wire [3:0] ssf_s = pin_b[11:8];
    wire [3:0] tsf_s = pin_b[7:4];
    wire [3:0] tsd_s = pin_b[3:0];
    wire byte_edge = ck_s & ~ck_prev;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pin_a <= '0;
            pin_b <= '0;
            ck_prev <= 1'b0;
        end
        else
        begin
            pin_a <= pin_now;
            pin_b <= pin_a;
            ck_prev <= ck_s;
        end
    end

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic sf_of(input logic [1:0] kind, input logic ssf, input logic tsf);
        return (kind == locm_pkg::inherent_protection) ? ssf : tsf;
    endfunction

    function automatic logic sd_of(input logic [1:0] kind, input logic tsd);
        return (kind == locm_pkg::inherent_protection) ? 1'b0 : tsd;
    endfunction

    function automatic logic [6:0] ho_next(input logic raw, input logic [6:0] cnt,
        input logic tick, input logic [6:0] lim);
        if (!raw)
            return 7'h00;
        return (tick && cnt != lim) ? cnt + 7'h01 : cnt;
    endfunction

    function automatic logic cmd_ok(input logic [2:0] cmd, input logic revert);
        if (!revert)
            return cmd <= locm_pkg::manual_switch_command_work;
        return cmd == locm_pkg::clear_command || cmd == locm_pkg::lockout_command ||
            cmd == locm_pkg::forced_switch_command_prot ||
            cmd == locm_pkg::manual_switch_command_prot;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    logic [11:0] conn_map;
    logic [3:0] conn_dir;
    logic [15:0] grp;
    logic [6:0] ho_period;
    logic [3:0] wtr_period;
    locm_pkg::switch_cmd_t cmd;
    logic [11:0] map_live;
    logic [15:0] grp_live;
    locm_pkg::sel_state_t state;
    locm_pkg::sel_state_t next_state;

    wire wr_map = reg_wr_i && reg_addr_i == `A_MAP;
    wire wr_dir = reg_wr_i && reg_addr_i == `A_DIR;
    wire wr_grp = reg_wr_i && reg_addr_i == `A_GRP;
    wire wr_ho = reg_wr_i && reg_addr_i == `A_HO;
    wire wr_wtr = reg_wr_i && reg_addr_i == `A_WTR;
    wire wr_cmd = reg_wr_i && reg_addr_i == `A_CMD;
    wire [6:0] ho_clamp = (reg_wdata_i[6:0] > `HO_MAX) ? `HO_MAX : reg_wdata_i[6:0];
    wire [3:0] wtr_clamp = (reg_wdata_i[3:0] < `WTR_MIN) ? `WTR_MIN :
        (reg_wdata_i[3:0] > `WTR_MAX) ? `WTR_MAX : reg_wdata_i[3:0];
    wire cmd_take = wr_cmd && cmd_ok(reg_wdata_i[2:0], grp_live[`G_REV]);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            conn_map <= `MAP_RST;
            conn_dir <= `DIR_RST;
            grp <= `GRP_RST;
            ho_period <= `HO_RST;
            wtr_period <= `WTR_RST;
            cmd <= locm_pkg::clear_command;
        end
        else
        begin
            if (wr_map)
                conn_map <= reg_wdata_i[11:0];
            if (wr_dir)
                conn_dir <= reg_wdata_i[3:0];
            if (wr_grp)
                grp <= reg_wdata_i[15:0];
            if (wr_ho)
                ho_period <= ho_clamp;
            if (wr_wtr)
                wtr_period <= wtr_clamp;
            if (cmd_take)
                cmd <= locm_pkg::switch_cmd_t'(reg_wdata_i[2:0]);
        end
    end

    // ****************************************
    // Condition detection
    // ****************************************
    logic [21:0] tick_cnt;
    logic [6:0] ho_w;
    logic [6:0] ho_p;
    logic [13:0] wtr_cnt;
    wire g_en = grp_live[`G_EN];
    wire [1:0] kind = grp_live[`G_KIND +: 2];
    wire revert = grp_live[`G_REV];
    wire [1:0] w_in = grp_live[`G_WIN +: 2];
    wire [1:0] p_in = grp_live[`G_PIN +: 2];
    wire tick = (tick_cnt == 22'(TICK_CYCLES - 1));
    wire raw_sf_w = sf_of(kind, ssf_s[w_in], tsf_s[w_in]);
    wire raw_sf_p = sf_of(kind, ssf_s[p_in], tsf_s[p_in]);
    wire raw_sd_w = sd_of(kind, tsd_s[w_in]);
    wire raw_sd_p = sd_of(kind, tsd_s[p_in]);
    wire raw_w = raw_sf_w | raw_sd_w;
    wire raw_p = raw_sf_p | raw_sd_p;
    wire held_w = raw_w && (ho_w == ho_period);
    wire held_p = raw_p && (ho_p == ho_period);
    wire sf_w = raw_sf_w & held_w;
    wire sf_p = raw_sf_p & held_p;
    wire sd_w = raw_sd_w & held_w;
    wire sd_p = raw_sd_p & held_p;
    wire [13:0] wtr_ticks = 14'(wtr_period) * `TICKS_PER_MIN;
    wire wtr_done = (wtr_cnt == wtr_ticks);
    wire busy = (state == locm_pkg::SEL_WTR) | (raw_w & ~held_w) | (raw_p & ~held_p);

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            tick_cnt <= '0;
            ho_w <= 7'h00;
            ho_p <= 7'h00;
            wtr_cnt <= '0;
        end
        else
        begin
            tick_cnt <= tick ? '0 : tick_cnt + 22'h000001;
            ho_w <= ho_next(raw_w, ho_w, tick, ho_period);
            ho_p <= ho_next(raw_p, ho_p, tick, ho_period);
            // Any working defect restarts the wait
            if (state != locm_pkg::SEL_WTR || raw_w)
                wtr_cnt <= '0;
            else if (tick && !wtr_done)
                wtr_cnt <= wtr_cnt + 14'h0001;
        end
    end

    // ****************************************
    // Selector
    // ****************************************
    // Lockout and protection fail outrank forced; fail and degrade outrank manual
    wire locm_pkg::demand_t demand =
        (cmd == locm_pkg::lockout_command || sf_p) ? locm_pkg::DEM_WORK :
        (cmd == locm_pkg::forced_switch_command_prot) ? locm_pkg::DEM_PROT :
        (cmd == locm_pkg::forced_switch_command_work) ? locm_pkg::DEM_WORK :
        sf_w ? locm_pkg::DEM_PROT :
        (sd_w && !sd_p) ? locm_pkg::DEM_PROT :
        (sd_p && !sd_w) ? locm_pkg::DEM_WORK :
        (cmd == locm_pkg::manual_switch_command_prot) ? locm_pkg::DEM_PROT :
        (cmd == locm_pkg::manual_switch_command_work) ? locm_pkg::DEM_WORK :
        locm_pkg::DEM_NONE;

    always_comb
    begin
        next_state = state;
        case (state)
            locm_pkg::SEL_WORK:
            begin
                if (demand == locm_pkg::DEM_PROT)
                    next_state = locm_pkg::SEL_PROT;
            end
            locm_pkg::SEL_PROT:
            begin
                if (demand == locm_pkg::DEM_WORK)
                    next_state = locm_pkg::SEL_WORK;
                else if (demand == locm_pkg::DEM_NONE && revert)
                    next_state = locm_pkg::SEL_WTR;
            end
            locm_pkg::SEL_WTR:
            begin
                if (demand == locm_pkg::DEM_PROT)
                    next_state = locm_pkg::SEL_PROT;
                else if (demand == locm_pkg::DEM_WORK || (revert && wtr_done))
                    next_state = locm_pkg::SEL_WORK;
                else if (!revert)
                    next_state = locm_pkg::SEL_PROT;
            end
            default:
                next_state = locm_pkg::SEL_WORK;
        endcase
        if (!g_en)
            next_state = locm_pkg::SEL_WORK;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            state <= locm_pkg::SEL_WORK;
        else
            state <= next_state;
    end

    // ****************************************
    // Data path
    // ****************************************
    logic [36:0] fifo_out;
    logic fifo_valid;
    logic fifo_in_ready;
    logic [3:0] fifo_level;
    logic gen_fs;
    logic [7:0] gen_data;
    wire pop = fifo_valid & out_ready_i;
    wire pop_fs = fifo_out[36];
    wire [3:0] pop_ssf = fifo_out[35:32];
    wire [31:0] pop_data = fifo_out[31:0];

    byte_fifo #(
        .WIDTH(37),
        .DEPTH(8)
    ) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(byte_edge),
        .in_ready_o(fifo_in_ready),
        .in_data_i({fs_s, ssf_s, data_s}),
        .out_valid_o(fifo_valid),
        .out_ready_i(out_ready_i),
        .out_data_o(fifo_out),
        .level_o(fifo_level)
    );

    unequipped_vc_generator u_gen (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .strobe_i(pop),
        .frame_start_i(pop_fs),
        .fs_o(gen_fs),
        .data_o(gen_data)
    );

    logic [31:0] next_data;
    logic [3:0] next_fs;
    logic [3:0] next_ssf;

    for (genvar o = 0; o < 4; o++)
    begin : g_out
        wire is_norm = g_en && grp_live[`G_NOUT +: 2] == 2'(o);
        wire is_bridge = g_en && (grp_live[`G_WOUT +: 2] == 2'(o) ||
            grp_live[`G_POUT +: 2] == 2'(o));
        // Exactly one source index per output, so no timeslot has two owners
        wire [1:0] src = is_norm ? ((state == locm_pkg::SEL_PROT) ? p_in : w_in) :
            is_bridge ? grp_live[`G_NIN +: 2] : map_live[o*3 +: 2];
        wire conn = is_norm | is_bridge | map_live[o*3 + `M_EN];
        assign next_data[o*8 +: 8] = conn ? pop_data[src*8 +: 8] : gen_data;
        assign next_fs[o] = conn ? pop_fs : gen_fs;
        assign next_ssf[o] = conn & pop_ssf[src];
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            map_live <= `MAP_RST;
            grp_live <= `GRP_RST;
            out_data_o <= '0;
            out_fs_o <= 4'h0;
            out_ssf_o <= 4'h0;
            out_strobe_o <= 1'b0;
            in_ready_o <= 1'b0;
        end
        else
        begin
            in_ready_o <= fifo_in_ready;
            out_strobe_o <= pop;
            // New settings are taken at a frame-start byte; that byte still leaves on the old ones, the next byte on the new
            if (pop && pop_fs && !busy)
            begin
                map_live <= conn_map;
                grp_live <= grp;
            end
            if (pop)
            begin
                out_data_o <= next_data;
                out_fs_o <= next_fs;
                out_ssf_o <= next_ssf;
            end
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    wire [31:0] stat = {20'h00000, fifo_level, busy, held_p, held_w, cmd, state};
    wire [31:0] rd_mux =
        (reg_addr_i == `A_MAP) ? {20'h00000, conn_map} :
        (reg_addr_i == `A_DIR) ? {28'h0000000, conn_dir} :
        (reg_addr_i == `A_GRP) ? {16'h0000, grp} :
        (reg_addr_i == `A_HO) ? {25'h0000000, ho_period} :
        (reg_addr_i == `A_WTR) ? {28'h0000000, wtr_period} :
        (reg_addr_i == `A_CMD) ? {29'h00000000, cmd} :
        (reg_addr_i == `A_STAT) ? stat : 32'h00000000;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            reg_rdata_o <= 32'h00000000;
        else
            reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
    end
endmodule
`default_nettype wire

/* common/locm_cfg.svh */
// Offsets, field positions, reset values and timing counts of the matrix.
// Assumes inclusion by bare name from design and bench files.
`ifndef LOCM_CFG_SVH
`define LOCM_CFG_SVH

// ****
// Register offsets
// ****
`define A_MAP 8'h00
`define A_DIR 8'h04
`define A_GRP 8'h08
`define A_HO 8'h0C
`define A_WTR 8'h10
`define A_CMD 8'h14
`define A_STAT 8'h18

// ****
// Field positions
// ****
`define M_EN 2
`define G_EN 0
`define G_KIND 1
`define G_REV 3
`define G_WIN 4
`define G_PIN 6
`define G_NOUT 8
`define G_NIN 10
`define G_WOUT 12
`define G_POUT 14

// ****
// Reset values
// ****
`define MAP_RST 12'h000
`define DIR_RST 4'h0
`define GRP_RST 16'h0000
`define HO_RST 7'h00
`define WTR_RST 4'h5

// ****
// Frame and timing
// ****
`define FRAME_US 500
`define FRAME_BYTES 7'h68
`define UNEQ_BYTE 8'h00
`define CLK_HZ 20000000
`define TICK_MS 100
`define SWITCH_MS 50
`define HO_MAX 7'h64
`define WTR_MIN 4'h5
`define WTR_MAX 4'hC
`define TICKS_PER_MIN 14'h0258

`endif

/* common/locm_pkg.sv */
// Types shared by the connection matrix files.
// Assumes nothing of its surroundings.
package locm_pkg;

    typedef enum logic [1:0] {
        SEL_WORK = 2'b00,
        SEL_PROT = 2'b01,
        SEL_WTR = 2'b10
    } sel_state_t;

    typedef enum logic [2:0] {
        clear_command = 3'b000,
        lockout_command = 3'b001,
        forced_switch_command_prot = 3'b010,
        forced_switch_command_work = 3'b011,
        manual_switch_command_prot = 3'b100,
        manual_switch_command_work = 3'b101
    } switch_cmd_t;

    typedef enum logic [1:0] {
        inherent_protection = 2'b00,
        non_intrusive_protection = 2'b01,
        sublayer_protection = 2'b10
    } protection_kind_t;

    typedef enum logic [1:0] {
        DEM_NONE = 2'b00,
        DEM_WORK = 2'b01,
        DEM_PROT = 2'b10
    } demand_t;

endpackage

/* verilog/byte_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 37,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign level_o = count;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
            mem[wr_ptr] <= in_data_i;
    end
endmodule
`default_nettype wire

/* verilog/unequipped_vc_generator.sv */
// Source of the unequipped VC-11: all-zero bytes with its own frame count.
// Assumes strobe_i marks each outgoing byte; frame_start_i realigns it.
`timescale 1ns/1ps
`default_nettype none
module unequipped_vc_generator (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic strobe_i,
    input wire logic frame_start_i,
    output logic fs_o,
    output logic [7:0] data_o
);
    logic [6:0] idx;

    // Keeps a valid frame start even when the timing input goes quiet
    assign fs_o = frame_start_i | (idx == 7'h00);
    // Label, V5 bit 4 and N2 all stay zero
    assign data_o = `UNEQ_BYTE;

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            idx <= 7'h00;
        else if (strobe_i)
        begin
            if (frame_start_i)
                idx <= 7'h01;
            else
                idx <= (idx == `FRAME_BYTES - 7'h01) ? 7'h00 : idx + 7'h01;
        end
    end
endmodule
`default_nettype wire

/* verif/locm_asserts.sv */
// Port checks of the connection matrix.
// Assumes one clock domain; bound to the top module at the foot.
`timescale 1ns/1ps
`default_nettype none
module locm_asserts (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic timing_clock_in_i,
    input wire logic [3:0] server_signal_fail_in_i,
    input wire logic in_ready_o,
    input wire logic out_ready_i,
    input wire logic [31:0] out_data_o,
    input wire logic [3:0] out_fs_o,
    input wire logic [3:0] out_ssf_o,
    input wire logic out_strobe_o
);
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // ****
    // Bytes since last frame start
    // ****
    logic [7:0] since_fs;
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
            since_fs <= 8'h00;
        else if (out_strobe_o)
            since_fs <= out_fs_o[3] ? 8'h00 : since_fs + 8'h01;
    end
    // ****
    // Properties
    // ****
    property p_rd_idle;
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data out of slot");
    property p_unmapped;
        reg_rd_i && reg_addr_i > 8'h18 |=> reg_rdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not 0");
    property p_data_hold;
        !out_strobe_o |-> $stable(out_data_o);
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("data moved");
    property p_flags_hold;
        !out_strobe_o |-> $stable(out_fs_o) && $stable(out_ssf_o);
    endproperty
    a_flags_hold: assert property (p_flags_hold) else $error("flags moved");
    property p_pop_ready;
        out_strobe_o |-> $past(out_ready_i);
    endproperty
    a_pop_ready: assert property (p_pop_ready) else $error("byte while stalled");
    property p_latency;
        $rose(timing_clock_in_i) && in_ready_o && out_ready_i |-> ##[2:16] out_strobe_o;
    endproperty
    a_latency: assert property (p_latency) else $error("byte not passed");
    property p_ssf_clear;
        (server_signal_fail_in_i == 4'h0)[*8] ##1 out_strobe_o |-> out_ssf_o == 4'h0;
    endproperty
    a_ssf_clear: assert property (p_ssf_clear) else $error("stray fail flag");
    property p_fs_period;
        out_strobe_o && since_fs == 8'h67 |-> out_fs_o[3];
    endproperty
    a_fs_period: assert property (p_fs_period) else $error("frame too long");
    property p_ready_rel;
        $fell(rst_i) |-> ##[0:2] in_ready_o;
    endproperty
    a_ready_rel: assert property (p_ready_rel) else $error("not ready");
    c_frame: cover property (out_strobe_o && out_fs_o == 4'hF);
    c_full: cover property (!in_ready_o);
    c_ssf: cover property (out_strobe_o && out_ssf_o != 4'h0);
endmodule
bind lower_order_connection_matrix locm_asserts u_locm_asserts (
    .clk_sys_i, .rst_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .timing_clock_in_i,
    .server_signal_fail_in_i, .in_ready_o, .out_ready_i, .out_data_o, .out_fs_o,
    .out_ssf_o, .out_strobe_o
);
`default_nettype wire

/* verif/far_end_model.sv */
// Far-side trail functions: byte clock, frame start, four byte streams.
// Assumes the matrix samples the byte clock in its own domain.
`timescale 1ns/1ps
`default_nettype none
module far_end_model #(
    parameter int HALF_NS = 200
) (
    output logic link_clk_o,
    output logic fs_o,
    output logic [31:0] data_o
);
    // ****
    // Byte stream, launched on the falling edge
    // ****
    int idx;
    initial
    begin
        link_clk_o = 1'b0;
        fs_o = 1'b1;
        data_o = 32'hA2A2A2A2;
        idx = 0;
        #13;
        forever
        begin
            #(HALF_NS) link_clk_o = 1'b1;
            #(HALF_NS) link_clk_o = 1'b0;
            // Frame scaled down in time, byte count kept
            idx = (idx == 103) ? 0 : idx + 1;
            fs_o = (idx == 0);
            // One fixed owner per timeslot; V5 bit 4 low
            data_o = (idx == 0) ? 32'hA2A2A2A2 : 32'h44332211;
        end
    end
endmodule
`default_nettype wire

/* verif/testbench.sv */
// Self-checking bench of the connection matrix.
// Assumes the checker and the far-side model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "locm_cfg.svh"
module testbench;
    logic clk_sys_i, rst_i, reg_wr_i, reg_rd_i, out_ready_i, in_ready_o, out_strobe_o;
    logic timing_clock_in_i, timing_frame_start_in_i;
    logic [7:0] reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, in_data_i, out_data_o;
    logic [3:0] server_signal_fail_in_i, trail_signal_fail_in_i, trail_signal_degrade_in_i;
    logic [3:0] out_fs_o, out_ssf_o;
    int num_errors = 0;
    int cmp_count = 0;
    far_end_model u_far (.link_clk_o(timing_clock_in_i), .fs_o(timing_frame_start_in_i),
        .data_o(in_data_i));
    lower_order_connection_matrix #(.TICK_CYCLES(4)) u_dut (.clk_sys_i, .rst_i, .reg_addr_i,
        .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .timing_clock_in_i,
        .timing_frame_start_in_i, .in_data_i, .server_signal_fail_in_i,
        .trail_signal_fail_in_i, .trail_signal_degrade_in_i, .in_ready_o, .out_ready_i,
        .out_data_o, .out_fs_o, .out_ssf_o, .out_strobe_o);
    // ****
    // Shared tasks
    // ****
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1;
        check(reg_rdata_o & m, e);
    endtask
    task automatic next_byte();
        int n = 0;
        do
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        while (out_strobe_o !== 1'b1 && n < 40);
        check(32'(n < 40), 32'h1);
    endtask
    task automatic next_frame();
        int k = 0;
        do
        begin
            next_byte();
            k++;
        end
        while (out_fs_o[3] !== 1'b1 && k < 110);
    endtask
    // Two frames skipped: new routing waits for a frame start
    task automatic check_frame(input logic [31:0] pay, input logic [3:0] con,
        input logic [3:0] ssf);
        logic [31:0] v5 = 32'h0;
        for (int i = 0; i < 4; i++)
            v5[8*i +: 8] = con[i] ? 8'hA2 : 8'h00;
        next_frame();
        next_frame();
        check(out_data_o, v5);
        check(32'(out_fs_o), 32'hF);
        for (int b = 1; b < 104; b++)
        begin
            next_byte();
            check(out_data_o, pay);
            check(32'(out_ssf_o), 32'(ssf));
        end
        next_byte();
        check(32'(out_fs_o), 32'hF);
    endtask
    task automatic test_done();
        $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs();
        rc(`A_MAP, `MAP_RST);
        rc(`A_DIR, `DIR_RST);
        rc(`A_GRP, `GRP_RST);
        rc(`A_HO, `HO_RST);
        rc(`A_WTR, `WTR_RST);
        rc(`A_CMD, 32'h0);
        wr(8'h40, 32'hFFFFFFFF);
        rc(8'h40, 32'h0);
        wr(`A_HO, 32'h7F);
        rc(`A_HO, `HO_MAX);
        wr(`A_WTR, 32'h2);
        rc(`A_WTR, `WTR_MIN);
        wr(`A_WTR, 32'hF);
        rc(`A_WTR, `WTR_MAX);
        wr(`A_DIR, 32'hF);
        rc(`A_DIR, 32'hF);
        wr(`A_WTR, 32'h5);
        wr(`A_HO, 32'hA);
    endtask
    task automatic t_routes();
        server_signal_fail_in_i <= 4'hF;
        check_frame(32'h0, 4'h0, 4'h0);
        server_signal_fail_in_i <= 4'h8;
        wr(`A_MAP, 32'h1FF);
        check_frame(32'h00444444, 4'h7, 4'h7);
        server_signal_fail_in_i <= 4'h0;
        wr(`A_MAP, 32'h0);
        check_frame(32'h0, 4'h0, 4'h0);
    endtask
    // Stall right after a byte, none in flight
    task automatic t_stall();
        next_byte();
        out_ready_i <= 1'b0;
        repeat (120) @(posedge clk_sys_i);
        #1;
        check(32'(in_ready_o), 32'h0);
        rc(`A_STAT, 32'h800, 32'hF00);
        out_ready_i <= 1'b1;
        repeat (30) @(posedge clk_sys_i);
        next_byte();
        rc(`A_STAT, 32'h0, 32'hF00);
    endtask
    task automatic t_protect();
        wr(`A_GRP, 32'h9849);
        trail_signal_fail_in_i <= 4'h1;
        check_frame(32'h00333311, 4'h7, 4'h0);
        server_signal_fail_in_i <= 4'h1;
        repeat (15) @(posedge clk_sys_i);
        rc(`A_STAT, 32'h0, 32'h3);
        repeat (50) @(posedge clk_sys_i);
        rc(`A_STAT, 32'h1, 32'h3);
        check_frame(32'h00333322, 4'h7, 4'h0);
        server_signal_fail_in_i <= 4'h0;
        repeat (20) @(posedge clk_sys_i);
        rc(`A_STAT, 32'h82, 32'h83);
        repeat (11000) @(posedge clk_sys_i);
        rc(`A_STAT, 32'h2, 32'h3);
        repeat (1200) @(posedge clk_sys_i);
        rc(`A_STAT, 32'h0, 32'h3);
        check_frame(32'h00333311, 4'h7, 4'h0);
    endtask
    task automatic t_commands();
        trail_signal_fail_in_i <= 4'h0;
        wr(`A_GRP, 32'h9841);
        next_frame();
        next_frame();
        for (int c = 0; c < 6; c++)
        begin
            wr(`A_CMD, 32'(c));
            repeat (4) @(posedge clk_sys_i);
            rc(`A_STAT, 32'((c << 2) | ((c == 2 || c == 4) ? 1 : 0)), 32'h1F);
        end
        wr(`A_CMD, 32'h0);
        wr(`A_GRP, 32'h9849);
        next_frame();
        next_frame();
        for (int c = 0; c < 6; c++)
        begin
            wr(`A_CMD, 32'(c));
            rc(`A_CMD, 32'((c == 3 || c == 5) ? c - 1 : c));
        end
    endtask
    // ****
    // Clock, watchdog, main sequence
    // ****
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        #3000000;
        num_errors++;
        test_done();
    end
    initial
    begin
        rst_i = 1'b1;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        out_ready_i = 1'b1;
        server_signal_fail_in_i = 4'h0;
        trail_signal_fail_in_i = 4'h0;
        trail_signal_degrade_in_i = 4'h0;
        repeat (5) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_regs();
        t_routes();
        t_stall();
        t_protect();
        t_commands();
        test_done();
    end
endmodule
`default_nettype wire
